// File: hw/pcs_64b66b_encode_transcode.v
// transmit 64b/66b encoder, rate matcher, transcoder and scrambler
`timescale 1ns/10ps
`include "pcs_enc_map.vh"
module pcs_64b66b_encode_transcode (
	input  wire         clock_i,
	input  wire         reset_n_i,
	input  wire [63:0]  txd_i,
	input  wire [7:0]   txc_i,
	input  wire         tx_valid_i,
	input  wire         eee_enable_i,
	input  wire         am_room_i,
	input  wire [65:0]  rx_block_i,
	input  wire         rx_valid_i,
	output wire [65:0]  coded_o,
	output wire         coded_valid_o,
	output wire         tx_err_o,
	output wire         deleted_o,
	output wire [256:0] xcoded_o,
	output wire         xcoded_valid_o,
	output wire [256:0] scrambled_o,
	output wire         scrambled_valid_o,
	output wire         rx_err_o
);

	// ***************************************************
	// lane character mapping
	// ***************************************************

	wire [55:0] code_w;
	wire [7:0]  ok_w;
	wire [7:0]  idle_w;
	wire [7:0]  term_w;
	wire [7:0]  start_w;
	wire [7:0]  seq_w;
	wire [7:0]  sig_w;

	// one mapper per lane, all eight identical
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : lane
			lane_char_map u_map (
				.ctrl_i   (txc_i[g]),
				.char_i   (txd_i[8*g +: 8]),
				.eee_en_i (eee_enable_i),
				.code_o   (code_w[7*g +: 7]),
				.ok_o     (ok_w[g]),
				.idle_o   (idle_w[g]),
				.term_o   (term_w[g]),
				.start_o  (start_w[g]),
				.seq_o    (seq_w[g]),
				.sig_o    (sig_w[g])
			);
		end
	endgenerate

	// ***************************************************
	// terminate type lookup
	// ***************************************************

	// block type for a terminate in lane k
	function [7:0] term_type;
		input [3:0] k;
		begin
			case (k)
				4'h0:    term_type = `BT_T0;
				4'h1:    term_type = `BT_T1;
				4'h2:    term_type = `BT_T2;
				4'h3:    term_type = `BT_T3;
				4'h4:    term_type = `BT_T4;
				4'h5:    term_type = `BT_T5;
				4'h6:    term_type = `BT_T6;
				default: term_type = `BT_T7;
			endcase
		end
	endfunction

	// ***************************************************
	// block encoder
	// ***************************************************

	reg  [63:0] pay;
	reg  [1:0]  sync;
	reg         bad;
	reg         idle_blk;
	reg         term_ok;
	reg  [3:0]  k;
	reg  [7:0]  tmask;
	integer     i;
	integer     n;
	integer     m;

	// first control lane, used to find a terminate
	// each process owns its loop index, a shared one would be multi-driven
	always @* begin
		k = 4'h8;
		for (n = 7; n >= 0; n = n - 1)
			if (txc_i[n])
				k = n[3:0];
	end

	// terminate is valid with data below and codes above
	always @* begin
		tmask   = 8'hff << k;
		term_ok = (k < 4'h8) && (txc_i == tmask);
		for (m = 0; m < 8; m = m + 1)
			if ((m > k) && !ok_w[m])
				term_ok = 1'h0;
		if (k < 4'h8)
			term_ok = term_ok && term_w[k[2:0]];
	end

	// payload starts zeroed so fillers leave as zero
	always @* begin
		pay      = {64{1'h0}};
		sync     = `SYNC_CTRL;
		bad      = 1'h0;
		idle_blk = 1'h0;
		if (!tx_valid_i) begin
			// nothing offered: fill with an idle block
			pay[7:0] = `BT_CTRL;
			for (i = 0; i < 8; i = i + 1)
				pay[`POS_CODE0+`CODE_W*i +: `CODE_W] = `CC_IDLE;
			idle_blk = 1'h1;
		end else if (txc_i == 8'h00) begin
			sync = `SYNC_DATA;
			pay  = txd_i;
		end else if ((txc_i == 8'hff) && (&ok_w)) begin
			// idle, lpi and error lanes as 7-bit codes
			pay[7:0] = `BT_CTRL;
			for (i = 0; i < 8; i = i + 1)
				pay[`POS_CODE0+`CODE_W*i +: `CODE_W] =
					code_w[7*i +: 7];
			idle_blk = &idle_w;
		end else if ((txc_i == 8'h01) && start_w[0]) begin
			// start implied by the type, lane0 carries none
			pay[7:0]  = `BT_START;
			pay[63:8] = txd_i[63:8];
		end else if ((txc_i == 8'h01) && (seq_w[0] || sig_w[0])
			&& (txd_i[63:32] == 32'h0000_0000)) begin
			pay[7:0]   = `BT_OSET;
			pay[31:8]  = txd_i[31:8];
			pay[`POS_OCODE +: `OC_W] =
				seq_w[0] ? `OC_SEQ : `OC_SIG;
			// of the ordered sets only sequence sets are candidates for deletion
			idle_blk = seq_w[0];
		end else if (term_ok) begin
			pay[7:0] = term_type(k);
			for (i = 0; i < 8; i = i + 1) begin
				if (i < k)
					pay[`POS_TDATA+8*i +: 8] = txd_i[8*i +: 8];
				else if (i > k)
					pay[`POS_CODE0+`CODE_W*i +: `CODE_W] =
						code_w[7*i +: 7];
			end
		end else begin
			// anything else is replaced by an error block
			pay[7:0] = `BT_CTRL;
			for (i = 0; i < 8; i = i + 1)
				pay[`POS_CODE0+`CODE_W*i +: `CODE_W] = `CC_ERR;
			bad = 1'h1;
		end
	end

	// ***************************************************
	// rate matching for marker room
	// ***************************************************

	reg  [3:0] credit_r;
	reg  [3:0] credit_nxt;
	wire       drop;

	// a deletable block is dropped while credit is owed
	assign drop = (credit_r != 4'h0) && idle_blk;

	// request and drop together leave credit unchanged
	always @* begin
		credit_nxt = credit_r;
		if (am_room_i && !drop && (credit_r != `DEL_MAX))
			credit_nxt = credit_r + 4'h1;
		else if (!am_room_i && drop)
			credit_nxt = credit_r - 4'h1;
	end

	// ***************************************************
	// encoded block register
	// ***************************************************

	reg [65:0] coded_r;
	reg        coded_valid_r;
	reg        tx_err_r;
	reg        deleted_r;

	// one transfer in, one block out unless dropped
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			credit_r      <= 4'h0;
			coded_r       <= {66{1'h0}};
			coded_valid_r <= 1'h0;
			tx_err_r      <= 1'h0;
			deleted_r     <= 1'h0;
		end else begin
			credit_r      <= credit_nxt;
			coded_r       <= {pay, sync};
			coded_valid_r <= !drop;
			tx_err_r      <= bad;
			deleted_r     <= drop;
		end
	end

	assign coded_o       = coded_r;
	assign coded_valid_o = coded_valid_r;
	assign tx_err_o      = tx_err_r;
	assign deleted_o     = deleted_r;

	// ***************************************************
	// transcoder
	// ***************************************************

	wire [256:0] xc_w;
	wire         xc_valid_w;

	// fed only with blocks that survived deletion
	xcode_257 u_xcode (
		.clock_i     (clock_i),
		.reset_n_i   (reset_n_i),
		.blk_i       (coded_r),
		.blk_valid_i (coded_valid_r),
		.xc_o        (xc_w),
		.xc_valid_o  (xc_valid_w)
	);

	assign xcoded_o       = xc_w;
	assign xcoded_valid_o = xc_valid_w;

	// ***************************************************
	// 58-bit self-synchronising scrambler
	// ***************************************************

	reg [57:0]  scr_r;
	reg [57:0]  scr_nxt;
	reg [256:0] scr_out;
	reg [256:0] scrambled_r;
	reg         scrambled_valid_r;
	integer     s;

	// bit 0 first, so the loop runs from the low end
	always @* begin
		scr_nxt = scr_r;
		scr_out = {257{1'h0}};
		for (s = 0; s < 257; s = s + 1) begin
			scr_out[s] = xc_w[s] ^ scr_nxt[`SCR_TAP_A]
				^ scr_nxt[`SCR_TAP_B];
			scr_nxt = {scr_nxt[56:0], scr_out[s]};
		end
	end

	// state only advances on a real transcoded block
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scr_r             <= {58{1'h0}};
			scrambled_r       <= {257{1'h0}};
			scrambled_valid_r <= 1'h0;
		end else begin
			scrambled_valid_r <= xc_valid_w;
			if (xc_valid_w) begin
				scr_r       <= scr_nxt;
				scrambled_r <= scr_out;
			end
		end
	end

	assign scrambled_o       = scrambled_r;
	assign scrambled_valid_o = scrambled_valid_r;

	// ***************************************************
	// received block check
	// ***************************************************

	reg        rx_bad;
	reg        rx_err_r;
	reg  [6:0] rcode;
	integer    r;

	// a line code is legal only if it is in the table
	always @* begin
		rx_bad = (rx_block_i[0] == rx_block_i[1]);
		rcode  = `CC_IDLE;
		if (rx_block_i[1:0] == `SYNC_CTRL) begin
			case (rx_block_i[9:2])
				`BT_CTRL: begin
					for (r = 0; r < 8; r = r + 1) begin
						rcode = rx_block_i[2+`POS_CODE0+`CODE_W*r
							+: `CODE_W];
						if ((rcode != `CC_IDLE) && (rcode != `CC_ERR)
							&& !((rcode == `CC_LPI) && eee_enable_i))
							rx_bad = 1'h1;
					end
				end
				`BT_START, `BT_OSET, `BT_T0, `BT_T1, `BT_T2,
				`BT_T3, `BT_T4, `BT_T5, `BT_T6, `BT_T7:
					rx_bad = rx_bad;
				default: rx_bad = 1'h1;
			endcase
		end
	end

	// flag sits for one cycle after each bad block
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rx_err_r <= 1'h0;
		else
			rx_err_r <= rx_valid_i && rx_bad;
	end

	assign rx_err_o = rx_err_r;

endmodule

// File: hw/pcs_enc_map.vh
// constants for the 64b/66b encoder and 256b/257b transcoder
`ifndef PCS_ENC_MAP_VH
`define PCS_ENC_MAP_VH
// sync headers as tx[1:0], bit 0 goes out first
`define SYNC_DATA 2'h2
`define SYNC_CTRL 2'h1
// block type field values
`define BT_CTRL  8'h1e
`define BT_START 8'h78
`define BT_OSET  8'h4b
`define BT_T0    8'h87
`define BT_T1    8'h99
`define BT_T2    8'haa
`define BT_T3    8'hb4
`define BT_T4    8'hcc
`define BT_T5    8'hd2
`define BT_T6    8'he1
`define BT_T7    8'hff
// interface control characters
`define CH_IDLE  8'h07
`define CH_LPI   8'h06
`define CH_ERR   8'hfe
`define CH_START 8'hfb
`define CH_TERM  8'hfd
`define CH_SEQ   8'h9c
`define CH_SIG   8'h5c
// 7-bit line control codes
`define CC_IDLE  7'h00
`define CC_LPI   7'h06
`define CC_ERR   7'h1e
// ordered set codes
`define OC_SEQ   4'h0
`define OC_SIG   4'hf
// field positions inside the 64-bit payload
`define POS_CODE0 8
`define CODE_W    7
`define POS_TDATA 8
`define POS_OCODE 32
`define OC_W      4
// field positions inside the 257-bit block
`define POS_XPL   5
`define NIB_LO    4
`define NIB_W     4
// scrambler taps, state bit 0 is the newest bit
`define SCR_TAP_A 38
`define SCR_TAP_B 57
// deletion credit limit
`define DEL_MAX   4'hf
`endif

// File: hw/lane_char_map.v
// one interface lane character mapped to a 7-bit line control code
`timescale 1ns/10ps
`include "pcs_enc_map.vh"
module lane_char_map (
	input  wire       ctrl_i,
	input  wire [7:0] char_i,
	input  wire       eee_en_i,
	output reg  [6:0] code_o,
	output reg        ok_o,
	output reg        idle_o,
	output wire       term_o,
	output wire       start_o,
	output wire       seq_o,
	output wire       sig_o
);
	// characters outside the table fall to the error code
	always @* begin
		code_o = `CC_ERR;
		ok_o   = 1'h0;
		idle_o = 1'h0;
		if (ctrl_i) begin
			case (char_i)
				`CH_IDLE: begin
					code_o = `CC_IDLE;
					ok_o   = 1'h1;
					idle_o = 1'h1;
				end
				// low power idle only once eee is agreed
				`CH_LPI: begin
					if (eee_en_i) begin
						code_o = `CC_LPI;
						ok_o   = 1'h1;
						idle_o = 1'h1;
					end
				end
				`CH_ERR: ok_o = 1'h1;
				default: ok_o = 1'h0;
			endcase
		end
	end
	// implied characters, only meaningful as control
	assign term_o  = ctrl_i && (char_i == `CH_TERM);
	assign start_o = ctrl_i && (char_i == `CH_START);
	assign seq_o   = ctrl_i && (char_i == `CH_SEQ);
	assign sig_o   = ctrl_i && (char_i == `CH_SIG);
endmodule

// File: hw/xcode_257.v
// gathers four 66-bit blocks into one 257-bit transcoded block
`timescale 1ns/10ps
`include "pcs_enc_map.vh"
module xcode_257 (
	input  wire         clock_i,
	input  wire         reset_n_i,
	input  wire [65:0]  blk_i,
	input  wire         blk_valid_i,
	output reg  [256:0] xc_o,
	output reg          xc_valid_o
);
	reg [65:0]  b0_r;
	reg [65:0]  b1_r;
	reg [65:0]  b2_r;
	reg [1:0]   idx_r;
	reg [263:0] grp;
	reg [255:0] pl;
	reg [256:0] xc_nxt;
	reg         all_data;
	reg         sync_ok;
	integer     j;
	integer     b;
	integer     c;

	// the incoming block is index 3, the newest of the group
	always @* begin
		grp      = {blk_i, b2_r, b1_r, b0_r};
		pl       = {256{1'h0}};
		xc_nxt   = {257{1'h0}};
		all_data = 1'h1;
		sync_ok  = 1'h1;
		c        = 0;
		for (j = 3; j >= 0; j = j - 1) begin
			pl[64*j +: 64] = grp[66*j+2 +: 64];
			if (grp[66*j +: 2] != `SYNC_DATA)
				all_data = 1'h0;
			if (grp[66*j] == grp[66*j+1])
				sync_ok = 1'h0;
			if (grp[66*j])
				c = j; // lowest control block wins
		end
		if (!sync_ok)
			c = 0;
		if (all_data) begin
			xc_nxt[0]     = 1'h1;
			xc_nxt[256:1] = pl;
		end else begin
			// header bits, forced high on a broken header
			for (j = 0; j < 4; j = j + 1)
				xc_nxt[j+1] = sync_ok ? grp[66*j+1] : 1'h1;
			// drop the second type nibble of block c
			for (b = 0; b < 252; b = b + 1) begin
				if (b < 64*c + `NIB_LO)
					xc_nxt[`POS_XPL+b] = pl[b];
				else
					xc_nxt[`POS_XPL+b] = pl[b+`NIB_W];
			end
		end
	end

	// one output strobe per four accepted blocks
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			b0_r       <= {66{1'h0}};
			b1_r       <= {66{1'h0}};
			b2_r       <= {66{1'h0}};
			idx_r      <= 2'h0;
			xc_o       <= {257{1'h0}};
			xc_valid_o <= 1'h0;
		end else begin
			xc_valid_o <= blk_valid_i && (idx_r == 2'h3);
			if (blk_valid_i) begin
				idx_r <= idx_r + 2'h1;
				case (idx_r)
					2'h0:    b0_r <= blk_i;
					2'h1:    b1_r <= blk_i;
					2'h2:    b2_r <= blk_i;
					default: xc_o <= xc_nxt;
				endcase
			end
		end
	end
endmodule

// File: testbench/pcs_enc_chk.sv
// assertion checker on the transmit coder ports
`timescale 1ns/10ps
module pcs_enc_chk (
	input wire        clock_i,
	input wire        reset_n_i,
	input wire [63:0] txd_i,
	input wire [7:0]  txc_i,
	input wire        tx_valid_i,
	input wire [65:0] rx_block_i,
	input wire        rx_valid_i,
	input wire [65:0] coded_o,
	input wire        coded_valid_o,
	input wire        tx_err_o,
	input wire        deleted_o,
	input wire        xcoded_valid_o,
	input wire        scrambled_valid_o,
	input wire        rx_err_o
);
	// kept blocks modulo four, a shadow of the group index
	reg [1:0] kept_r;
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			kept_r <= 2'h0;
		else if (coded_valid_o)
			kept_r <= kept_r + 2'h1;
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	data_sync_a: assert property (tx_valid_i && txc_i == 8'h00 |=>
		coded_valid_o && coded_o == {$past(txd_i), 2'h2})
		else $error("data block mismatch");
	ctrl_sync_a: assert property (tx_valid_i && txc_i != 8'h00 |=>
		deleted_o || coded_o[1:0] == 2'h1) else $error("control header");
	idle_fill_a: assert property (!tx_valid_i |=> deleted_o ||
		coded_o == {56'h0, 8'h1e, 2'h1}) else $error("inserted idle");
	err_fill_a: assert property (tx_err_o |->
		coded_o == {{8{7'h1e}}, 8'h1e, 2'h1}) else $error("error block");
	drop_slot_a: assert property (deleted_o |->
		!coded_valid_o && !tx_err_o) else $error("deleted slot");
	one_block_a: assert property ($past(reset_n_i) |->
		coded_valid_o ^ deleted_o) else $error("block per cycle");
	group_end_a: assert property (xcoded_valid_o ==
		($past(coded_valid_o) && $past(kept_r) == 2'h3))
		else $error("group strobe");
	scr_next_a: assert property (xcoded_valid_o |=>
		scrambled_valid_o ##1 !scrambled_valid_o)
		else $error("scrambler strobe");
	rx_hdr_a: assert property (rx_valid_i &&
		rx_block_i[0] == rx_block_i[1] |=> rx_err_o)
		else $error("rx header error");
	rx_type_a: assert property (rx_valid_i &&
		rx_block_i[9:0] == 10'h001 |=> rx_err_o) else $error("rx type");
	cover property (xcoded_valid_o);
	cover property (deleted_o);
	cover property (tx_err_o);
	cover property (rx_err_o);
endmodule

// File: testbench/rs_client_model.sv
// client model presenting transfers on the falling edge
`timescale 1ns/10ps
module rs_client_model (
	input  wire        clock_i,
	input  wire [63:0] d_i,
	input  wire [7:0]  c_i,
	input  wire        v_i,
	output reg  [63:0] txd_o = 64'h0,
	output reg  [7:0]  txc_o = 8'h00,
	output reg         tx_valid_o = 1'b0
);
	// flags travel with their lanes; with nothing offered the lines
	// toggle so a stale octet never looks like fresh data
	always @(negedge clock_i) begin
		tx_valid_o <= v_i;
		txc_o <= v_i ? c_i : ~txc_o;
		txd_o <= v_i ? d_i : ~txd_o;
	end
endmodule

// File: testbench/pcs_64b66b_encode_transcode_test.sv
// self-checking bench for the coder and transcoder
`timescale 1ns/10ps
module pcs_64b66b_encode_transcode_test;
	localparam [65:0] idle_blk = {56'h0, 8'h1e, 2'h1};
	localparam [65:0] err_blk  = {{8{7'h1e}}, 8'h1e, 2'h1};
	reg          clock_i = 1'b0;
	reg          reset_n_i = 1'b0;
	reg  [63:0]  d_q = 64'h0;
	reg  [7:0]   c_q = 8'h00;
	reg          v_q = 1'b0;
	reg          am_room_i = 1'b0;
	reg          eee_enable_i = 1'b0;
	reg  [65:0]  rx_block_i = 66'h0;
	reg          rx_valid_i = 1'b0;
	reg  [65:0]  rq_blk = 66'h0;
	reg          rq_v = 1'b0;
	reg          rq_am = 1'b0;
	reg          rq_eee = 1'b0;
	wire [63:0]  txd_i;
	wire [7:0]   txc_i;
	wire         tx_valid_i, coded_valid_o, tx_err_o, deleted_o;
	wire [65:0]  coded_o;
	wire [256:0] xcoded_o, scrambled_o;
	wire         xcoded_valid_o, scrambled_valid_o, rx_err_o;
	integer      error_cnt = 0;
	integer      check_count = 0;
	integer      nk = 0;
	always #25 clock_i = ~clock_i;
	rs_client_model cli_u (.clock_i(clock_i), .d_i(d_q), .c_i(c_q),
		.v_i(v_q), .txd_o(txd_i), .txc_o(txc_i), .tx_valid_o(tx_valid_i));
	pcs_64b66b_encode_transcode dut_u (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .txd_i(txd_i), .txc_i(txc_i),
		.tx_valid_i(tx_valid_i), .eee_enable_i(eee_enable_i),
		.am_room_i(am_room_i), .rx_block_i(rx_block_i),
		.rx_valid_i(rx_valid_i), .coded_o(coded_o),
		.coded_valid_o(coded_valid_o), .tx_err_o(tx_err_o),
		.deleted_o(deleted_o), .xcoded_o(xcoded_o),
		.xcoded_valid_o(xcoded_valid_o), .scrambled_o(scrambled_o),
		.scrambled_valid_o(scrambled_valid_o), .rx_err_o(rx_err_o));
	// ****************************************
	// helpers
	// ****************************************
	task chk(input string nm, input [256:0] e, input [256:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// one transfer per cycle, results read just after the taking edge
	task step(input [63:0] d, input [7:0] c, input v);
		begin
			d_q = d;
			c_q = c;
			v_q = v;
			@(negedge clock_i);
			am_room_i = rq_am;
			eee_enable_i = rq_eee;
			rx_block_i = rq_blk;
			rx_valid_i = rq_v;
			rq_am = 1'b0;
			rq_v = 1'b0;
			@(posedge clock_i);
			#1;
		end
	endtask
	task blk(input [65:0] e, input k, input er);
		begin
			chk("coded_valid_o", k, coded_valid_o);
			chk("deleted_o", !k, deleted_o);
			chk("tx_err_o", er, tx_err_o);
			if (k) begin
				chk("coded_o", e, coded_o);
				nk = nk + 1;
			end
		end
	endtask
	task idle;
		begin
			step(64'h0, 8'h00, 1'b0);
			blk(idle_blk, 1'b1, 1'b0);
		end
	endtask
	// reference transcode; a header bit of one marks a data block
	function [256:0] xexp(input [255:0] p, input [3:0] h);
		integer b, k, c;
		begin
			xexp = {p, 1'b1};
			if (h != 4'hf) begin
				c = 0;
				for (b = 3; b >= 0; b = b - 1)
					if (!h[b]) c = b;
				xexp = {252'h0, h, 1'b0};
				k = 5;
				for (b = 0; b < 256; b = b + 1)
					if (b < 64 * c + 4 || b > 64 * c + 7) begin
						xexp[k] = p[b];
						k = k + 1;
					end
			end
		end
	endfunction
	// x^58 + x^39 + 1 in sent order, seeded by the last 58 bits sent
	function [256:0] scr_exp(input [256:0] x, input [256:0] prev);
		reg [314:0] w;
		integer     n;
		begin
			w = {257'h0, prev[256:199]};
			for (n = 0; n < 257; n = n + 1)
				w[58 + n] = x[n] ^ w[n + 19] ^ w[n];
			scr_exp = w[314:58];
		end
	endfunction
	// ****************************************
	// scenarios
	// ****************************************
	task t_group(input [3:0] h);
		reg [255:0] pl;
		reg [63:0]  d;
		reg [256:0] sp;
		integer     j;
		begin
			while (nk % 4 != 0)
				idle;
			for (j = 0; j < 4; j = j + 1) begin
				d = 64'h0123_4567_89ab_cdef ^ {8{j[7:0]}};
				if (h[j]) begin
					step(d, 8'h00, 1'b1);
					blk({d, 2'h2}, 1'b1, 1'b0);
					pl[64 * j +: 64] = d;
				end else begin
					idle;
					pl[64 * j +: 64] = idle_blk[65:2];
				end
			end
			// previous group's scrambled word seeds the expectation
			sp = scrambled_o;
			idle;
			chk("xcoded_valid_o", 1'b1, xcoded_valid_o);
			chk("xcoded_o", xexp(pl, h), xcoded_o);
			idle;
			chk("scrambled_valid_o", 1'b1, scrambled_valid_o);
			chk("scrambled_o", scr_exp(xexp(pl, h), sp), scrambled_o);
		end
	endtask
	task t_ctrl;
		begin
			step({56'h11_2233_4455_6677, 8'hfb}, 8'h01, 1'b1);
			blk({56'h11_2233_4455_6677, 8'h78, 2'h1}, 1, 0);
			step({{7{8'h07}}, 8'hfd}, 8'hff, 1'b1);
			blk({56'h0, 8'h87, 2'h1}, 1'b1, 1'b0);
			step({32'h0, 24'hab_cdef, 8'h9c}, 8'h01, 1'b1);
			blk({32'h0, 24'hab_cdef, 8'h4b, 2'h1}, 1, 0);
			step({{7{8'h07}}, 8'hfe}, 8'hff, 1'b1);
			blk({49'h0, 7'h1e, 8'h1e, 2'h1}, 1'b1, 1'b0);
			step({{7{8'h07}}, 8'h00}, 8'hff, 1'b1);
			blk(err_blk, 1'b1, 1'b1);
			step({8{8'h06}}, 8'hff, 1'b1);
			blk(err_blk, 1'b1, 1'b1);
			rq_eee = 1'b1;
			step({8{8'h06}}, 8'hff, 1'b1);
			blk({{8{7'h06}}, 8'h1e, 2'h1}, 1'b1, 1'b0);
			rq_eee = 1'b0;
		end
	endtask
	task t_delete;
		begin
			rq_am = 1'b1;
			step(64'h5a5a_0f0f_a5a5_f0f0, 8'h00, 1'b1);
			blk({64'h5a5a_0f0f_a5a5_f0f0, 2'h2}, 1'b1, 1'b0);
			step(64'h0, 8'h00, 1'b0);
			blk(66'h0, 1'b0, 1'b0);
			idle;
		end
	endtask
	task t_rx(input [65:0] b, input e);
		begin
			rq_blk = b;
			rq_v = 1'b1;
			// the flag stands for one cycle only, look while it stands
			idle;
			chk("rx_err_o", e, rx_err_o);
			idle;
			chk("rx_err_o", 1'b0, rx_err_o);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d errors %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		reset_n_i = 1'b1;
		@(posedge clock_i);
		#1;
		blk(idle_blk, 1'b1, 1'b0);
		t_group(4'hf);
		t_group(4'hb);
		t_group(4'h0);
		t_ctrl;
		t_delete;
		t_group(4'he);
		t_rx(66'h0, 1'b1);
		t_rx({56'h0, 8'h00, 2'h1}, 1'b1);
		t_rx({{8{7'h06}}, 8'h1e, 2'h1}, 1'b1);
		t_rx(idle_blk, 1'b0);
		complete_run;
	end
endmodule
bind pcs_64b66b_encode_transcode pcs_enc_chk chk_u (.clock_i(clock_i),
	.reset_n_i(reset_n_i), .txd_i(txd_i), .txc_i(txc_i),
	.tx_valid_i(tx_valid_i), .rx_block_i(rx_block_i),
	.rx_valid_i(rx_valid_i), .coded_o(coded_o),
	.coded_valid_o(coded_valid_o), .tx_err_o(tx_err_o),
	.deleted_o(deleted_o), .xcoded_valid_o(xcoded_valid_o),
	.scrambled_valid_o(scrambled_valid_o), .rx_err_o(rx_err_o));
